// file: verilog/exec_core.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - xor combines operand into accumulator bit by bit
// - xor clears v, sets n, z
// - xor opcodes with their cycle counts
// - increment adds one, carry untouched
// - v set when operand was 7f
// - low index increment never touches high
// - increment opcodes with their cycle counts
// - jump loads pc with effective address
// - jump opcodes with their cycle counts
// - call loads pc with effective address; return address is past its operands
// - call pushes low then high byte
// - sp points at next free location
// - call opcodes with their cycle counts
// - load accumulator sets n, z, clears v
// - load accumulator opcodes with cycle counts
// - pair load high first, 16-bit flags
// - pair load opcodes 45 and 55
// - load low index sets n, z
module exec_core (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [15:0] mem_addr,
	output logic mem_rd,
	output logic mem_wr,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata
);
	typedef enum logic [2:0] {st_idle, st_fetch, st_read, st_write, st_pad} state_e;

	// ==========================================
	// opcode table
	function automatic exec_pkg::decode_s decode_op(input logic [15:0] code);
		exec_pkg::decode_s d;
		d = '{1'b0, exec_pkg::xor_into_acc, exec_pkg::immediate_mode, 3'd1};
		case (code)
			16'h00a8: d = '{1'b1, exec_pkg::xor_into_acc, exec_pkg::immediate_mode, 3'd2};
			16'h00b8: d = '{1'b1, exec_pkg::xor_into_acc, exec_pkg::direct_mode, 3'd3};
			16'h00c8: d = '{1'b1, exec_pkg::xor_into_acc, exec_pkg::extended_mode, 3'd4};
			16'h00d8: d = '{1'b1, exec_pkg::xor_into_acc, exec_pkg::indexed_offset16_mode, 3'd4};
			16'h00e8: d = '{1'b1, exec_pkg::xor_into_acc, exec_pkg::indexed_offset8_mode, 3'd3};
			16'h00f8: d = '{1'b1, exec_pkg::xor_into_acc, exec_pkg::indexed_plain_mode, 3'd2};
			16'h9ed8: d = '{1'b1, exec_pkg::xor_into_acc, exec_pkg::stack_offset16_mode, 3'd5};
			16'h9ee8: d = '{1'b1, exec_pkg::xor_into_acc, exec_pkg::stack_offset8_mode, 3'd4};
			16'h003c: d = '{1'b1, exec_pkg::increment_op, exec_pkg::direct_mode, 3'd4};
			16'h004c: d = '{1'b1, exec_pkg::increment_op, exec_pkg::acc_inh_mode, 3'd1};
			16'h005c: d = '{1'b1, exec_pkg::increment_op, exec_pkg::index_low_inh_mode, 3'd1};
			16'h006c: d = '{1'b1, exec_pkg::increment_op, exec_pkg::indexed_offset8_mode, 3'd4};
			16'h007c: d = '{1'b1, exec_pkg::increment_op, exec_pkg::indexed_plain_mode, 3'd3};
			16'h9e6c: d = '{1'b1, exec_pkg::increment_op, exec_pkg::stack_offset8_mode, 3'd5};
			16'h00bc: d = '{1'b1, exec_pkg::jump_op, exec_pkg::direct_mode, 3'd2};
			16'h00cc: d = '{1'b1, exec_pkg::jump_op, exec_pkg::extended_mode, 3'd3};
			16'h00dc: d = '{1'b1, exec_pkg::jump_op, exec_pkg::indexed_offset16_mode, 3'd4};
			16'h00ec: d = '{1'b1, exec_pkg::jump_op, exec_pkg::indexed_offset8_mode, 3'd3};
			16'h00fc: d = '{1'b1, exec_pkg::jump_op, exec_pkg::indexed_plain_mode, 3'd3};
			16'h00bd: d = '{1'b1, exec_pkg::call_subroutine, exec_pkg::direct_mode, 3'd4};
			16'h00cd: d = '{1'b1, exec_pkg::call_subroutine, exec_pkg::extended_mode, 3'd5};
			16'h00dd: d = '{1'b1, exec_pkg::call_subroutine, exec_pkg::indexed_offset16_mode, 3'd6};
			16'h00ed: d = '{1'b1, exec_pkg::call_subroutine, exec_pkg::indexed_offset8_mode, 3'd5};
			16'h00fd: d = '{1'b1, exec_pkg::call_subroutine, exec_pkg::indexed_plain_mode, 3'd4};
			16'h00a6: d = '{1'b1, exec_pkg::load_acc, exec_pkg::immediate_mode, 3'd2};
			16'h00b6: d = '{1'b1, exec_pkg::load_acc, exec_pkg::direct_mode, 3'd3};
			16'h00c6: d = '{1'b1, exec_pkg::load_acc, exec_pkg::extended_mode, 3'd4};
			16'h00d6: d = '{1'b1, exec_pkg::load_acc, exec_pkg::indexed_offset16_mode, 3'd4};
			16'h00e6: d = '{1'b1, exec_pkg::load_acc, exec_pkg::indexed_offset8_mode, 3'd3};
			16'h00f6: d = '{1'b1, exec_pkg::load_acc, exec_pkg::indexed_plain_mode, 3'd2};
			16'h9ed6: d = '{1'b1, exec_pkg::load_acc, exec_pkg::stack_offset16_mode, 3'd5};
			16'h9ee6: d = '{1'b1, exec_pkg::load_acc, exec_pkg::stack_offset8_mode, 3'd4};
			16'h0045: d = '{1'b1, exec_pkg::load_index_pair, exec_pkg::immediate_mode, 3'd3};
			16'h0055: d = '{1'b1, exec_pkg::load_index_pair, exec_pkg::direct_mode, 3'd4};
			16'h00ae: d = '{1'b1, exec_pkg::load_index_low, exec_pkg::immediate_mode, 3'd2};
			16'h00be: d = '{1'b1, exec_pkg::load_index_low, exec_pkg::direct_mode, 3'd3};
			16'h00ce: d = '{1'b1, exec_pkg::load_index_low, exec_pkg::extended_mode, 3'd4};
			16'h00de: d = '{1'b1, exec_pkg::load_index_low, exec_pkg::indexed_offset16_mode, 3'd4};
			16'h00ee: d = '{1'b1, exec_pkg::load_index_low, exec_pkg::indexed_offset8_mode, 3'd3};
			16'h00fe: d = '{1'b1, exec_pkg::load_index_low, exec_pkg::indexed_plain_mode, 3'd2};
			16'h9ede: d = '{1'b1, exec_pkg::load_index_low, exec_pkg::stack_offset16_mode, 3'd5};
			16'h9eee: d = '{1'b1, exec_pkg::load_index_low, exec_pkg::stack_offset8_mode, 3'd4};
			default: d.ok = 1'b0;
		endcase
		return d;
	endfunction

	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] sel);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				m[8*b +: 8] = val[8*b +: 8];
			end
		end
		return m;
	endfunction

	// ==========================================
	// state
	state_e state;
	state_e next_state;
	logic [7:0] acc;
	logic [15:0] index;
	logic [15:0] pc;
	logic [15:0] sp;
	logic [7:0] condition_flags;
	logic [15:0] opcode;
	exec_pkg::decode_s dec;
	logic bad;
	logic [2:0] cnt;
	logic [1:0] idx;
	logic [15:0] opnd;
	logic [15:0] data;

	// ==========================================
	// register bus decode
	wire busy = (state != st_idle);
	wire bus_take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire bus_write = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
	logic [31:0] rd_word;
	always_comb begin
		unique case (wb_adr_i)
			exec_pkg::off_acc: rd_word = {24'h000000, acc};
			exec_pkg::off_index: rd_word = {16'h0000, index};
			exec_pkg::off_pc: rd_word = {16'h0000, pc};
			exec_pkg::off_sp: rd_word = {16'h0000, sp};
			exec_pkg::off_flags: rd_word = {24'h000000, condition_flags | exec_pkg::flags_fixed_ones};
			exec_pkg::off_cmd: rd_word = {14'h0000, bad, busy, opcode};
			default: rd_word = 32'h00000000;
		endcase
	end
	wire [31:0] wr_word = lane_merge(rd_word, wb_dat_i, wb_sel_i);
	// bus writes to the architectural registers are ignored while an instruction runs
	wire reg_wr = bus_write & ~busy;
	wire wr_acc = reg_wr & (wb_adr_i == exec_pkg::off_acc);
	wire wr_index = reg_wr & (wb_adr_i == exec_pkg::off_index);
	wire wr_pc = reg_wr & (wb_adr_i == exec_pkg::off_pc);
	wire wr_sp = reg_wr & (wb_adr_i == exec_pkg::off_sp);
	wire wr_flags = reg_wr & (wb_adr_i == exec_pkg::off_flags);
	wire wr_cmd = reg_wr & (wb_adr_i == exec_pkg::off_cmd);
	wire exec_pkg::decode_s new_dec = decode_op(wr_word[15:0]);
	wire start = wr_cmd & new_dec.ok;

	// ==========================================
	// addressing
	wire prefixed = (opcode[15:8] == exec_pkg::prefix_byte);
	wire [15:0] op_len = prefixed ? 16'h0002 : 16'h0001;
	wire [1:0] nbytes = exec_pkg::operand_bytes(dec.op, dec.mode);
	wire [15:0] opnd_base = pc + op_len;
	wire [15:0] ret_addr = opnd_base + {14'h0000, nbytes};
	wire is_inh = (dec.mode == exec_pkg::acc_inh_mode) | (dec.mode == exec_pkg::index_low_inh_mode);
	wire is_mem = ~is_inh & (dec.mode != exec_pkg::immediate_mode);
	wire is_branch = (dec.op == exec_pkg::jump_op) | (dec.op == exec_pkg::call_subroutine);
	wire needs_read = is_mem & ~is_branch;
	wire [1:0] read_cnt = (dec.op == exec_pkg::load_index_pair) ? 2'd2 : 2'd1;
	wire is_call = (dec.op == exec_pkg::call_subroutine);
	wire needs_write = is_call | (is_mem & (dec.op == exec_pkg::increment_op));
	wire [1:0] write_cnt = is_call ? 2'd2 : 2'd1;
	logic [15:0] ea;
	always_comb begin
		unique case (dec.mode)
			exec_pkg::direct_mode: ea = {8'h00, opnd[7:0]};
			exec_pkg::extended_mode: ea = opnd;
			exec_pkg::indexed_offset16_mode: ea = index + opnd;
			exec_pkg::indexed_offset8_mode: ea = index + {8'h00, opnd[7:0]};
			exec_pkg::stack_offset16_mode: ea = sp + opnd;
			exec_pkg::stack_offset8_mode: ea = sp + {8'h00, opnd[7:0]};
			default: ea = index;
		endcase
	end

	// ==========================================
	// result unit
	wire [7:0] alu_operand = (dec.mode == exec_pkg::immediate_mode) ? opnd[7:0] :
		(dec.mode == exec_pkg::acc_inh_mode) ? acc :
		(dec.mode == exec_pkg::index_low_inh_mode) ? index[7:0] : data[7:0];
	wire [15:0] pair_word = (dec.mode == exec_pkg::immediate_mode) ? opnd : data;
	logic [7:0] alu_result;
	logic [7:0] alu_flags;
	result_unit alu (
		.op(dec.op),
		.operand(alu_operand),
		.acc(acc),
		.word(pair_word),
		.flags_in(condition_flags),
		.result(alu_result),
		.flags_out(alu_flags)
	);

	// ==========================================
	// sequencer
	// every access takes one cycle; the pad state stretches to the table count
	wire last_step = (idx == ((state == st_fetch) ? nbytes - 2'd1 :
		(state == st_read) ? read_cnt - 2'd1 : write_cnt - 2'd1));
	wire commit = (state == st_pad) & (cnt == dec.cycles);
	wire exec_pkg::decode_s cur = start ? new_dec : dec;
	wire first_fetch = (exec_pkg::operand_bytes(cur.op, cur.mode) != 2'd0);
	// plain indexed memory forms read without fetching any operand
	wire new_mem = (new_dec.mode == exec_pkg::indexed_plain_mode);
	wire new_branch = (new_dec.op == exec_pkg::jump_op) | (new_dec.op == exec_pkg::call_subroutine);
	wire needs_read_new = new_mem & ~new_branch;
	// a plain indexed call has nothing to fetch, so it goes straight to its pushes
	wire needs_write_new = (new_dec.op == exec_pkg::call_subroutine);
	always_comb begin
		next_state = state;
		unique case (state)
			st_idle: begin
				if (start) begin
					next_state = first_fetch ? st_fetch : needs_read_new ? st_read : needs_write_new ? st_write : st_pad;
				end
			end
			st_fetch: begin
				if (last_step) begin
					next_state = needs_read ? st_read : (needs_write ? st_write : st_pad);
				end
			end
			st_read: begin
				if (last_step) begin
					next_state = needs_write ? st_write : st_pad;
				end
			end
			st_write: begin
				if (last_step) begin
					next_state = st_pad;
				end
			end
			st_pad: begin
				if (commit) begin
					next_state = st_idle;
				end
			end
		endcase
	end

	// ==========================================
	// memory side
	assign mem_rd = (state == st_fetch) | (state == st_read);
	assign mem_wr = (state == st_write);
	assign mem_addr = (state == st_fetch) ? opnd_base + {14'h0000, idx} :
		(state == st_read) ? ea + {14'h0000, idx} :
		(state == st_write) ? (is_call ? sp : ea) : 16'h0000;
	assign mem_wdata = is_call ? ((idx == 2'd0) ? ret_addr[7:0] : ret_addr[15:8]) : alu_result;

	// ==========================================
	// next values of the programmer registers
	wire acc_dest = (dec.op == exec_pkg::xor_into_acc) | (dec.op == exec_pkg::load_acc) |
		((dec.op == exec_pkg::increment_op) & (dec.mode == exec_pkg::acc_inh_mode));
	wire xl_dest = (dec.op == exec_pkg::load_index_low) |
		((dec.op == exec_pkg::increment_op) & (dec.mode == exec_pkg::index_low_inh_mode));
	wire [7:0] next_acc = wr_acc ? wr_word[7:0] : (commit & acc_dest) ? alu_result : acc;
	wire [15:0] next_index = wr_index ? wr_word[15:0] :
		(commit & (dec.op == exec_pkg::load_index_pair)) ? pair_word :
		(commit & xl_dest) ? {index[15:8], alu_result} : index;
	wire [15:0] next_pc = wr_pc ? wr_word[15:0] : commit ? (is_branch ? ea : ret_addr) : pc;
	wire [15:0] next_sp = wr_sp ? wr_word[15:0] : (mem_wr & is_call) ? sp - 16'h0001 : sp;
	wire [7:0] next_flags = wr_flags ? wr_word[7:0] : commit ? alu_flags : condition_flags;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			acc <= exec_pkg::acc_rst;
			index <= exec_pkg::index_rst;
			pc <= exec_pkg::pc_rst;
			sp <= exec_pkg::sp_rst;
			condition_flags <= exec_pkg::flags_rst;
		end else begin
			acc <= next_acc;
			index <= next_index;
			pc <= next_pc;
			sp <= next_sp;
			condition_flags <= next_flags;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state <= st_idle;
			cnt <= 3'd0;
			idx <= 2'd0;
		end else begin
			state <= next_state;
			cnt <= start ? 3'd1 : busy ? cnt + 3'd1 : 3'd0;
			idx <= (next_state != state) ? 2'd0 : (mem_rd | mem_wr) ? idx + 2'd1 : 2'd0;
		end
	end

	// first fetched byte lands high once the second shifts in
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			opcode <= 16'h0000;
			dec <= '{1'b0, exec_pkg::xor_into_acc, exec_pkg::immediate_mode, 3'd1};
			bad <= 1'b0;
			opnd <= 16'h0000;
			data <= 16'h0000;
		end else begin
			if (wr_cmd) begin
				opcode <= wr_word[15:0];
				dec <= new_dec;
				bad <= ~new_dec.ok;
			end
			opnd <= start ? 16'h0000 : (state == st_fetch) ? {opnd[7:0], mem_rdata} : opnd;
			data <= start ? 16'h0000 : (state == st_read) ? {data[7:0], mem_rdata} : data;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_take;
			wb_dat_o <= bus_take ? rd_word : wb_dat_o;
		end
	end

	// ==========================================
	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	a_xor_result: assert property (
		commit && dec.op == exec_pkg::xor_into_acc |=> acc == ($past(acc) ^ $past(alu_operand)))
		else $error("xor result wrong");
	a_xor_flags: assert property (
		commit && dec.op == exec_pkg::xor_into_acc |=> !condition_flags[exec_pkg::flag_v] &&
		condition_flags[exec_pkg::flag_n] == acc[7] && condition_flags[exec_pkg::flag_z] == (acc == 8'h00) &&
		condition_flags[exec_pkg::flag_c] == $past(condition_flags[exec_pkg::flag_c]))
		else $error("xor flags wrong");
	a_xor_timing: assert property (
		start && new_dec.op == exec_pkg::xor_into_acc && new_dec.mode == exec_pkg::stack_offset16_mode
		|-> !commit [*5] ##1 commit)
		else $error("xor stack form not five cycles");
	a_inc_carry: assert property (
		commit && dec.op == exec_pkg::increment_op |=> condition_flags[exec_pkg::flag_c] ==
		$past(condition_flags[exec_pkg::flag_c]) && $past(alu_result) == $past(alu_operand) + 8'h01)
		else $error("increment wrong or carry changed");
	a_inc_overflow: assert property (
		commit && dec.op == exec_pkg::increment_op |=>
		condition_flags[exec_pkg::flag_v] == ($past(alu_operand) == 8'h7f))
		else $error("increment overflow wrong");
	a_index_high: assert property (
		commit && dec.op == exec_pkg::increment_op && dec.mode == exec_pkg::index_low_inh_mode
		|=> index[15:8] == $past(index[15:8]) && index[7:0] == $past(index[7:0]) + 8'h01)
		else $error("low index increment leaked");
	a_inc_timing: assert property (
		start && new_dec.op == exec_pkg::increment_op && new_dec.mode == exec_pkg::acc_inh_mode |=> commit)
		else $error("accumulator increment not one cycle");
	a_jump_flags: assert property (
		commit && is_branch |=> pc == $past(ea) && condition_flags == $past(condition_flags))
		else $error("jump target or flags wrong");
	a_jump_timing: assert property (
		start && new_dec.op == exec_pkg::jump_op && new_dec.mode == exec_pkg::indexed_plain_mode
		|-> ##3 commit)
		else $error("plain indexed jump not three cycles");
	a_push_low: assert property (
		mem_wr && is_call && idx == 2'd0 |-> mem_wdata == ret_addr[7:0] ##1 mem_wdata == $past(ret_addr[15:8]))
		else $error("return address push wrong");
	a_push_sp: assert property (
		mem_wr && is_call |-> mem_addr == sp ##1 sp == $past(sp) - 16'h0001)
		else $error("stack pointer not next free");
	a_call_timing: assert property (
		start && new_dec.op == exec_pkg::call_subroutine && new_dec.mode == exec_pkg::indexed_offset16_mode
		|-> ##6 commit)
		else $error("call offset16 form not six cycles");
	a_lda_flags: assert property (
		commit && dec.op == exec_pkg::load_acc |=> acc == $past(alu_operand) &&
		!condition_flags[exec_pkg::flag_v] && condition_flags[exec_pkg::flag_n] == acc[7])
		else $error("load accumulator wrong");
	a_pair_flags: assert property (
		commit && dec.op == exec_pkg::load_index_pair |=> !condition_flags[exec_pkg::flag_v] &&
		condition_flags[exec_pkg::flag_n] == index[15] && condition_flags[exec_pkg::flag_z] == (index == 16'h0000))
		else $error("pair load flags wrong");
	a_fetch_order: assert property (
		state == st_fetch && idx == 2'd1 |-> mem_addr == $past(mem_addr) + 16'h0001)
		else $error("operand bytes not sequential");

	c_xor_done: cover property (commit && dec.op == exec_pkg::xor_into_acc);
	c_call_done: cover property (commit && dec.op == exec_pkg::call_subroutine);
	c_inc_wrap: cover property (commit && dec.op == exec_pkg::increment_op && alu_operand == 8'h7f);
	c_pair_load: cover property (commit && dec.op == exec_pkg::load_index_pair);
endmodule
`default_nettype wire

// file: shared/exec_pkg.sv
package exec_pkg;
	// ==========================================
	// register map, byte addresses
	localparam logic [7:0] off_acc = 8'h00;
	localparam logic [7:0] off_index = 8'h04;
	localparam logic [7:0] off_pc = 8'h08;
	localparam logic [7:0] off_sp = 8'h0c;
	localparam logic [7:0] off_flags = 8'h10;
	localparam logic [7:0] off_cmd = 8'h14;

	// ==========================================
	// condition_flags layout and reset values
	localparam int flag_v = 7;
	localparam int flag_h = 4;
	localparam int flag_i = 3;
	localparam int flag_n = 2;
	localparam int flag_z = 1;
	localparam int flag_c = 0;
	localparam logic [7:0] flags_fixed_ones = 8'h60;
	localparam logic [7:0] flags_rst = 8'h68;
	localparam logic [7:0] acc_rst = 8'h00;
	localparam logic [15:0] index_rst = 16'h0000;
	localparam logic [15:0] pc_rst = 16'h0000;
	localparam logic [15:0] sp_rst = 16'h00ff;
	localparam int cmd_busy_bit = 16;
	localparam int cmd_bad_bit = 17;

	// ==========================================
	// opcode constants
	localparam logic [7:0] prefix_byte = 8'h9e;
	localparam logic [7:0] inc_overflow_val = 8'h7f;

	typedef enum logic [2:0] {
		xor_into_acc, increment_op, jump_op, call_subroutine,
		load_acc, load_index_pair, load_index_low
	} op_e;

	typedef enum logic [3:0] {
		acc_inh_mode, index_low_inh_mode, immediate_mode, direct_mode,
		extended_mode, indexed_offset16_mode, indexed_offset8_mode,
		indexed_plain_mode, stack_offset16_mode, stack_offset8_mode
	} mode_e;

	typedef struct packed {
		logic ok;
		op_e op;
		mode_e mode;
		logic [2:0] cycles;
	} decode_s;

	// operand bytes that follow the opcode
	function automatic logic [1:0] operand_bytes(input op_e op, input mode_e mode);
		unique case (mode)
			immediate_mode: return (op == load_index_pair) ? 2'd2 : 2'd1;
			direct_mode, indexed_offset8_mode, stack_offset8_mode: return 2'd1;
			extended_mode, indexed_offset16_mode, stack_offset16_mode: return 2'd2;
			default: return 2'd0;
		endcase
	endfunction
endpackage

// file: verilog/result_unit.sv
`timescale 1ns/1ps
`default_nettype none
module result_unit (
	input wire exec_pkg::op_e op,
	input wire logic [7:0] operand,
	input wire logic [7:0] acc,
	input wire logic [15:0] word,
	input wire logic [7:0] flags_in,
	output logic [7:0] result,
	output logic [7:0] flags_out
);
	// ==========================================
	// byte results and flag updates
	always_comb begin
		flags_out = flags_in;
		result = operand;
		unique case (op)
			exec_pkg::xor_into_acc: begin
				result = acc ^ operand;
				flags_out[exec_pkg::flag_v] = 1'b0;
			end
			exec_pkg::increment_op: begin
				result = operand + 8'h01;
				flags_out[exec_pkg::flag_v] = (operand == exec_pkg::inc_overflow_val);
			end
			exec_pkg::load_acc, exec_pkg::load_index_low: begin
				flags_out[exec_pkg::flag_v] = 1'b0;
			end
			exec_pkg::load_index_pair: begin
				flags_out[exec_pkg::flag_v] = 1'b0;
				flags_out[exec_pkg::flag_n] = word[15];
				flags_out[exec_pkg::flag_z] = (word == 16'h0000);
			end
			exec_pkg::jump_op, exec_pkg::call_subroutine: begin
				result = operand;
			end
		endcase
		// byte results share the n and z formula; carry is never touched
		if (op != exec_pkg::load_index_pair && op != exec_pkg::jump_op && op != exec_pkg::call_subroutine) begin
			flags_out[exec_pkg::flag_n] = result[7];
			flags_out[exec_pkg::flag_z] = (result == 8'h00);
		end
	end
endmodule
`default_nettype wire

// file: verif/mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// byte memory, same-cycle read
module mem_model (
	input wire logic clk,
	input wire logic [15:0] mem_addr,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [0:65535];
	logic [7:0] last = 8'h00;
	// idle bus shows inverted last byte, so a stray sample never matches by luck
	assign mem_rdata = mem_rd ? mem[mem_addr] : ~last;
	always @(posedge clk) begin
		if (mem_rd)
			last <= mem[mem_addr];
		if (mem_wr)
			mem[mem_addr] <= mem_wdata;
	end
endmodule
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 1'b0, reset_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rd;
	logic [3:0] sel = 4'h0;
	wire logic [31:0] dat_o;
	wire logic ack, mem_rd, mem_wr;
	wire logic [15:0] mem_addr;
	wire logic [7:0] mem_wdata, mem_rdata;
	int err_count = 0, total_checks = 0;
	exec_core uut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack), .mem_addr(mem_addr), .mem_rd(mem_rd),
		.mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
	mem_model mem (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata));
	initial forever #4 clk = ~clk;
	// ==========================================
	// bus tasks
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) err_count++;
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		chk($sformatf("reg_%h", a), rd, exp);
	endtask
	// opcode at 0200, operands right after it
	task automatic run(input logic [15:0] op, input logic [7:0] b0, input logic [7:0] b1);
		int n;
		logic [15:0] p;
		p = (op[15:8] == exec_pkg::prefix_byte) ? 16'h0202 : 16'h0201;
		mem.mem[p] = b0;
		mem.mem[p + 16'h1] = b1;
		wb(1'b1, exec_pkg::off_pc, 32'h0200);
		wb(1'b1, exec_pkg::off_cmd, {16'h0, op});
		n = 0;
		do begin
			wb(1'b0, exec_pkg::off_cmd, 32'h0);
			n++;
		end while (rd[exec_pkg::cmd_busy_bit] !== 1'b0 && n < 40);
		if (n >= 40) err_count++;
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ==========================================
	// tests
	initial begin
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		rchk(exec_pkg::off_acc, 32'h0);
		rchk(exec_pkg::off_index, 32'h0);
		rchk(exec_pkg::off_sp, 32'h00ff);
		rchk(exec_pkg::off_flags, 32'h68);
		rchk(8'h20, 32'h0);
		wb(1'b1, exec_pkg::off_flags, 32'hff);
		run(16'h00a6, 8'h80, 8'h00);
		rchk(exec_pkg::off_acc, 32'h80);
		rchk(exec_pkg::off_flags, 32'h7d);
		rchk(exec_pkg::off_pc, 32'h0202);
		mem.mem[16'h0300] = 8'hc3;
		run(16'h00c8, 8'h03, 8'h00);
		rchk(exec_pkg::off_acc, 32'h43);
		rchk(exec_pkg::off_flags, 32'h79);
		rchk(exec_pkg::off_pc, 32'h0203);
		wb(1'b1, exec_pkg::off_acc, 32'h7f);
		run(16'h004c, 8'h00, 8'h00);
		rchk(exec_pkg::off_acc, 32'h80);
		rchk(exec_pkg::off_flags, 32'hfd);
		wb(1'b1, exec_pkg::off_index, 32'h12ff);
		run(16'h005c, 8'h00, 8'h00);
		rchk(exec_pkg::off_index, 32'h1200);
		rchk(exec_pkg::off_flags, 32'h7b);
		run(16'h0045, 8'h80, 8'h00);
		rchk(exec_pkg::off_index, 32'h8000);
		rchk(exec_pkg::off_flags, 32'h7d);
		rchk(exec_pkg::off_pc, 32'h0203);
		run(16'h00cc, 8'h12, 8'h34);
		rchk(exec_pkg::off_pc, 32'h1234);
		rchk(exec_pkg::off_flags, 32'h7d);
		run(16'h00bd, 8'h40, 8'h00);
		rchk(exec_pkg::off_pc, 32'h0040);
		rchk(exec_pkg::off_sp, 32'h00fd);
		chk("push_low", {24'h0, mem.mem[16'h00ff]}, 32'h02);
		chk("push_high", {24'h0, mem.mem[16'h00fe]}, 32'h02);
		run(16'h00fd, 8'h00, 8'h00);
		rchk(exec_pkg::off_pc, 32'h8000);
		rchk(exec_pkg::off_sp, 32'h00fb);
		chk("push_x_low", {24'h0, mem.mem[16'h00fd]}, 32'h01);
		chk("push_x_high", {24'h0, mem.mem[16'h00fc]}, 32'h02);
		run(16'h9ed8, 8'h00, 8'h02);
		rchk(exec_pkg::off_acc, 32'h81);
		rchk(exec_pkg::off_pc, 32'h0204);
		wb(1'b1, exec_pkg::off_cmd, 32'h0001);
		wb(1'b0, exec_pkg::off_cmd, 32'h0);
		chk("bad_op", {31'h0, rd[exec_pkg::cmd_bad_bit]}, 32'h1);
		wrap_up();
	end
	// watchdog: all tests need a few hundred cycles
	initial begin
		#200000;
		err_count++;
		wrap_up();
	end
endmodule
`default_nettype wire
